//--- core/pcr_config_file.sv
`timescale 1ns/1ps
module pcr_config_file (
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic                       clk_en,
	input  wire logic                       rail_por_n,
	input  wire logic [1:0]                 base_sel,
	input  wire logic [15:0]                io_addr,
	input  wire logic                       io_wr,
	input  wire logic                       io_rd,
	input  wire logic [7:0]                 io_wdata,
	output logic      [7:0]                 io_rdata,
	output logic                            io_hit,
	output logic      [pcr_pkg::PCR_NDEV-1:0] dev_active,
	output logic      [pcr_pkg::PCR_NDEV*16-1:0] dev_base0,
	output logic      [pcr_pkg::PCR_NDEV*16-1:0] dev_base1,
	output logic      [pcr_pkg::PCR_NDEV*4-1:0]  dev_irq_num,
	output logic      [pcr_pkg::PCR_NDEV-1:0] dev_irq_high,
	output logic      [pcr_pkg::PCR_NDEV-1:0] dev_irq_level,
	output logic      [pcr_pkg::PCR_NDEV*3-1:0]  dev_dma0,
	output logic      [pcr_pkg::PCR_NDEV*3-1:0]  dev_dma1,
	output logic                            soft_reset_pulse
);
	import pcr_pkg::*;

	// ==========================================================
	// host decode
	logic [15:0] base_addr;
	logic        cfg_on;
	logic        at_index;
	logic        at_data;

	always_comb begin
		base_addr = PCR_BASE_A;
		if (base_sel == PCR_BASE_SEL_B) begin
			base_addr = PCR_BASE_B;
		end
	end

	assign cfg_on   = (base_sel == PCR_BASE_SEL_A) || (base_sel == PCR_BASE_SEL_B);
	assign at_index = cfg_on && (io_addr == base_addr);
	assign at_data  = cfg_on && (io_addr == base_addr + PCR_DATA_OFF);
	assign io_hit   = at_index || at_data;

	// ==========================================================
	// index and global registers
	logic [7:0] index_reg;
	logic [7:0] selector_reg;
	logic [7:0] gcfg1_reg;
	logic [7:0] gcfg2_reg;
	logic       wr_idx;
	logic       wr_data;
	logic       soft_rst;
	logic       banked;
	logic       sel_valid;
	logic [3:0] sel;
	logic       wr_sel;
	logic       wr_g1;
	logic       wr_g2;
	logic       bank_clr;

	assign wr_idx   = clk_en && io_wr && at_index;
	assign wr_data  = clk_en && io_wr && at_data;
	assign banked   = index_reg >= PCR_IX_BANKED;
	assign sel      = selector_reg[3:0];
	assign sel_valid = (selector_reg <= PCR_DEV_LAST)
		&& (selector_reg != PCR_DEV_HOLE);
	assign soft_rst = wr_data && (index_reg == PCR_IX_GCFG1)
		&& io_wdata[PCR_SWR_BIT];
	assign soft_reset_pulse = soft_rst;
	assign wr_sel   = wr_data && (index_reg == PCR_IX_SELECTOR);
	assign wr_g1    = wr_data && (index_reg == PCR_IX_GCFG1);
	assign wr_g2    = wr_data && (index_reg == PCR_IX_GCFG2);
	// soft reset shares the bank clear with the hardware one
	assign bank_clr = !resetn || soft_rst;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			index_reg <= PCR_ZERO;
		end else if (wr_idx) begin
			index_reg <= io_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			selector_reg <= PCR_ZERO;
		end else if (soft_rst) begin
			selector_reg <= PCR_ZERO;
		end else if (wr_sel) begin
			selector_reg <= io_wdata;
		end
	end

	// lock and the scratch it guards survive a soft reset
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			gcfg1_reg <= PCR_GCFG1_RST;
		end else if (soft_rst) begin
			gcfg1_reg[PCR_GEN_BIT] <= PCR_GCFG1_RST[PCR_GEN_BIT];
		end else if (wr_g1) begin
			gcfg1_reg[PCR_GEN_BIT] <= io_wdata[PCR_GEN_BIT];
			if (!gcfg1_reg[PCR_LOCK_BIT]) begin
				gcfg1_reg[7:6] <= io_wdata[7:6];
				gcfg1_reg[PCR_LOCK_BIT] <= io_wdata[PCR_LOCK_BIT];
			end
		end
	end

	// battery domain: only the rail power-up clears it
	always_ff @(posedge clk_sys) begin
		if (!rail_por_n) begin
			gcfg2_reg <= PCR_GCFG2_RST;
		end else if (wr_g2) begin
			gcfg2_reg <= (io_wdata & PCR_GCFG2_MASK)
				| (gcfg2_reg & ~PCR_GCFG2_MASK);
		end
	end

	// ==========================================================
	// per-device banks
	logic [7:0] act_q  [PCR_NDEV];
	logic [7:0] b0h_q  [PCR_NDEV];
	logic [7:0] b0l_q  [PCR_NDEV];
	logic [7:0] b1h_q  [PCR_NDEV];
	logic [7:0] b1l_q  [PCR_NDEV];
	logic [7:0] irqn_q [PCR_NDEV];
	logic [7:0] irqt_q [PCR_NDEV];
	logic [7:0] dma0_q [PCR_NDEV];
	logic [7:0] dma1_q [PCR_NDEV];
	logic [PCR_NDEV-1:0] reach;

	genvar gi;
	generate
		for (gi = 0; gi < PCR_NDEV; gi++) begin : g_dev
			localparam logic [3:0] DEV = 4'(gi);
			logic wr_here;
			logic on;
			logic wr_act;
			logic wr_b0h;
			logic wr_b0l;
			logic wr_b1h;
			logic wr_b1l;
			logic wr_irqn;
			logic wr_irqt;
			logic wr_dma0;
			logic wr_dma1;

			// clock and wakeup units ignore the global enable, keeping only their activate bit
			if (gi == PCR_DEV_CLOCK || gi == PCR_DEV_WAKEUP) begin : g_aon
				assign on = act_q[gi][PCR_ACT_BIT];
			end else begin : g_std
				assign on = act_q[gi][PCR_ACT_BIT]
					&& gcfg1_reg[PCR_GEN_BIT];
			end
			assign dev_active[gi] = on;
			assign reach[gi] = on;
			assign wr_here = wr_data && banked && sel_valid && (sel == DEV);
			assign wr_act  = wr_here && (index_reg == PCR_IX_ACTIVATE);
			assign wr_b0h  = wr_here && (index_reg == PCR_IX_B0_HI);
			assign wr_b0l  = wr_here && (index_reg == PCR_IX_B0_LO);
			// absent second range and dma selects drop the write
			assign wr_b1h  = wr_here && (index_reg == PCR_IX_B1_HI)
				&& PCR_HAS_BASE1[gi];
			assign wr_b1l  = wr_here && (index_reg == PCR_IX_B1_LO)
				&& PCR_HAS_BASE1[gi];
			assign wr_irqn = wr_here && (index_reg == PCR_IX_IRQ_NUM);
			assign wr_irqt = wr_here && (index_reg == PCR_IX_IRQ_TYPE);
			assign wr_dma0 = wr_here && (index_reg == PCR_IX_DMA0)
				&& PCR_HAS_DMA[gi];
			assign wr_dma1 = wr_here && (index_reg == PCR_IX_DMA1)
				&& PCR_HAS_DMA[gi];

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					act_q[gi] <= PCR_ZERO;
				end else if (wr_act) begin
					act_q[gi] <= io_wdata & PCR_ACT_MASK;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					b0h_q[gi] <= PCR_ZERO;
				end else if (wr_b0h) begin
					b0h_q[gi] <= io_wdata;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					b0l_q[gi] <= PCR_ZERO;
				end else if (wr_b0l) begin
					b0l_q[gi] <= io_wdata;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					b1h_q[gi] <= PCR_ZERO;
				end else if (wr_b1h) begin
					b1h_q[gi] <= io_wdata;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					b1l_q[gi] <= PCR_ZERO;
				end else if (wr_b1l) begin
					b1l_q[gi] <= io_wdata;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					irqn_q[gi] <= PCR_ZERO;
				end else if (wr_irqn) begin
					irqn_q[gi] <= io_wdata & PCR_IRQN_MASK;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					irqt_q[gi] <= PCR_ZERO;
				end else if (wr_irqt) begin
					irqt_q[gi] <= io_wdata & PCR_IRQT_MASK;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					dma0_q[gi] <= PCR_DMA_NONE;
				end else if (wr_dma0) begin
					dma0_q[gi] <= io_wdata & PCR_DMA_MASK;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (bank_clr) begin
					dma1_q[gi] <= PCR_DMA_NONE;
				end else if (wr_dma1) begin
					dma1_q[gi] <= io_wdata & PCR_DMA_MASK;
				end
			end

			// resources only attach while active
			always_comb begin
				dev_base0[gi*16 +: 16] = on ? {b0h_q[gi], b0l_q[gi]} : 16'h0000;
				dev_base1[gi*16 +: 16] = on ? {b1h_q[gi], b1l_q[gi]} : 16'h0000;
				dev_irq_num[gi*4 +: 4] = PCR_IRQ_NONE;
				if (on && irqn_q[gi][3:0] <= PCR_IRQ_MAX) begin
					dev_irq_num[gi*4 +: 4] = irqn_q[gi][3:0];
				end
				dev_irq_high[gi]  = on && irqt_q[gi][PCR_POL_BIT];
				dev_irq_level[gi] = on && irqt_q[gi][PCR_TYPE_BIT];
				dev_dma0[gi*3 +: 3] = (on && dma0_q[gi][2:0] <= PCR_DMA_LAST)
					? dma0_q[gi][2:0] : PCR_DMA_NONE[2:0];
				dev_dma1[gi*3 +: 3] = (on && dma1_q[gi][2:0] <= PCR_DMA_LAST)
					? dma1_q[gi][2:0] : PCR_DMA_NONE[2:0];
			end
		end
	endgenerate

	// ==========================================================
	// read path
	logic [7:0] rd_next;

	always_comb begin
		rd_next = PCR_ZERO;
		if (at_index) begin
			rd_next = index_reg;
		end else if (index_reg == PCR_IX_SELECTOR) begin
			rd_next = selector_reg;
		end else if (index_reg == PCR_IX_IDENT) begin
			rd_next = PCR_IDENT_VAL;
		end else if (index_reg == PCR_IX_GCFG1) begin
			rd_next = gcfg1_reg & PCR_GCFG1_MASK;
		end else if (index_reg == PCR_IX_GCFG2) begin
			rd_next = gcfg2_reg & PCR_GCFG2_MASK;
		end else if (index_reg == PCR_IX_REV) begin
			rd_next = PCR_REV_VAL;
		end else if (banked) begin
			if (index_reg == PCR_IX_DMA0 || index_reg == PCR_IX_DMA1) begin
				rd_next = PCR_DMA_NONE;
			end
			if (sel_valid) begin
				if (index_reg == PCR_IX_ACTIVATE) begin
					rd_next = act_q[sel];
				end else if (index_reg == PCR_IX_B0_HI) begin
					rd_next = b0h_q[sel];
				end else if (index_reg == PCR_IX_B0_LO) begin
					rd_next = b0l_q[sel];
				end else if (index_reg == PCR_IX_B1_HI) begin
					rd_next = b1h_q[sel];
				end else if (index_reg == PCR_IX_B1_LO) begin
					rd_next = b1l_q[sel];
				end else if (index_reg == PCR_IX_IRQ_NUM) begin
					rd_next = irqn_q[sel];
				end else if (index_reg == PCR_IX_IRQ_TYPE) begin
					rd_next = irqt_q[sel];
				end else if (index_reg == PCR_IX_DMA0) begin
					rd_next = dma0_q[sel];
				end else if (index_reg == PCR_IX_DMA1) begin
					rd_next = dma1_q[sel];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			io_rdata <= PCR_ZERO;
		end else if (clk_en && io_rd && io_hit) begin
			io_rdata <= rd_next;
		end
	end
endmodule

//--- core/pcr_pkg.sv
package pcr_pkg;
	// ==========================================================
	// host port
	localparam logic [15:0] PCR_BASE_A      = 16'h002E;
	localparam logic [15:0] PCR_BASE_B      = 16'h015C;
	localparam logic [1:0]  PCR_BASE_SEL_A  = 2'h2;
	localparam logic [1:0]  PCR_BASE_SEL_B  = 2'h3;
	localparam logic [1:0]  PCR_BASE_NOCFG  = 2'h1;
	localparam logic [15:0] PCR_DATA_OFF    = 16'h0001;
	// ==========================================================
	// register indexes
	localparam logic [7:0] PCR_IX_SELECTOR  = 8'h07;
	localparam logic [7:0] PCR_IX_IDENT     = 8'h20;
	localparam logic [7:0] PCR_IX_GCFG1     = 8'h21;
	localparam logic [7:0] PCR_IX_GCFG2     = 8'h22;
	localparam logic [7:0] PCR_IX_REV       = 8'h27;
	localparam logic [7:0] PCR_IX_BANKED    = 8'h30;
	localparam logic [7:0] PCR_IX_ACTIVATE  = 8'h30;
	localparam logic [7:0] PCR_IX_B0_HI     = 8'h60;
	localparam logic [7:0] PCR_IX_B0_LO     = 8'h61;
	localparam logic [7:0] PCR_IX_B1_HI     = 8'h62;
	localparam logic [7:0] PCR_IX_B1_LO     = 8'h63;
	localparam logic [7:0] PCR_IX_IRQ_NUM   = 8'h70;
	localparam logic [7:0] PCR_IX_IRQ_TYPE  = 8'h71;
	localparam logic [7:0] PCR_IX_DMA0      = 8'h74;
	localparam logic [7:0] PCR_IX_DMA1      = 8'h75;
	// ==========================================================
	// logical devices
	localparam int         PCR_NDEV         = 9;
	localparam logic [7:0] PCR_DEV_CLOCK    = 8'h00;
	localparam logic [7:0] PCR_DEV_WAKEUP   = 8'h01;
	localparam logic [7:0] PCR_DEV_HOLE     = 8'h04;
	localparam logic [7:0] PCR_DEV_LAST     = 8'h08;
	// devices holding a second base range and dma selects
	localparam logic [8:0] PCR_HAS_BASE1    = 9'h001;
	localparam logic [8:0] PCR_HAS_DMA      = 9'h004;
	// ==========================================================
	// field layout and reset values
	localparam int         PCR_ACT_BIT      = 0;
	localparam int         PCR_GEN_BIT      = 0;
	localparam int         PCR_SWR_BIT      = 1;
	localparam int         PCR_LOCK_BIT     = 5;
	localparam int         PCR_POL_BIT      = 1;
	localparam int         PCR_TYPE_BIT     = 0;
	localparam logic [7:0] PCR_ACT_MASK     = 8'h01;
	localparam logic [7:0] PCR_SCR1_MASK    = 8'hC0;
	localparam logic [7:0] PCR_GCFG1_MASK   = 8'hE1;
	localparam logic [7:0] PCR_GCFG2_MASK   = 8'h72;
	localparam logic [7:0] PCR_IRQN_MASK    = 8'h0F;
	localparam logic [7:0] PCR_IRQT_MASK    = 8'h03;
	localparam logic [7:0] PCR_DMA_MASK     = 8'h07;
	localparam logic [7:0] PCR_GCFG1_RST    = 8'h01;
	localparam logic [7:0] PCR_GCFG2_RST    = 8'h02;
	localparam logic [7:0] PCR_DMA_NONE     = 8'h04;
	localparam logic [7:0] PCR_ZERO         = 8'h00;
	localparam logic [3:0] PCR_IRQ_MAX      = 4'hC;
	localparam logic [3:0] PCR_IRQ_NONE     = 4'h0;
	localparam logic [2:0] PCR_DMA_LAST     = 3'h3;
	// identity values, arbitrary
	localparam logic [7:0] PCR_IDENT_VAL    = 8'h5A;
	localparam logic [7:0] PCR_REV_VAL      = 8'h0A;
endpackage

//--- test/pcr_config_file_assertions.sv
`timescale 1ns/1ps
module pcr_chk
	import pcr_pkg::*;
(
	input wire logic                  clk_sys,
	input wire logic                  resetn,
	input wire logic                  clk_en,
	input wire logic [1:0]            base_sel,
	input wire logic [15:0]           io_addr,
	input wire logic                  io_wr,
	input wire logic                  io_rd,
	input wire logic [7:0]            io_wdata,
	input wire logic [7:0]            io_rdata,
	input wire logic                  io_hit,
	input wire logic [PCR_NDEV-1:0]   dev_active,
	input wire logic [PCR_NDEV*16-1:0] dev_base0,
	input wire logic [PCR_NDEV*4-1:0] dev_irq_num,
	input wire logic [PCR_NDEV*3-1:0] dev_dma0,
	input wire logic                  soft_reset_pulse
);
	// ==========================================================
	// helpers
	logic ixa;
	assign ixa = clk_en && base_sel == PCR_BASE_SEL_A && io_addr == PCR_BASE_A;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// checks
	hit_decode_a: assert property (io_hit == (base_sel[1] && io_addr[15:1] ==
		(base_sel[0] ? PCR_BASE_B[15:1] : PCR_BASE_A[15:1])))
		else $error("io_hit decode wrong");
	index_read_a: assert property (ixa && io_wr ##2 ixa && io_rd
		|=> io_rdata == $past(io_wdata, 3)) else $error("index readback wrong");
	rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved without read");
	soft_pulse_a: assert property (soft_reset_pulse
		|-> io_wr && io_hit && io_wdata[PCR_SWR_BIT]) else $error("stray soft reset");
	soft_clear_a: assert property (soft_reset_pulse && clk_en
		|=> dev_active[8:2] == '0) else $error("soft reset left device active");
	reset_clear_a: assert property (disable iff (1'b0) !resetn
		|=> dev_active[8:2] == '0 && io_rdata == PCR_ZERO)
		else $error("reset left state");
	inactive_a: assert property (!dev_active[2] |-> dev_base0[47:32] == '0
		&& dev_irq_num[11:8] == PCR_IRQ_NONE && dev_dma0[8:6] == 3'h4)
		else $error("inactive device attached");
	range_a: assert property (dev_irq_num[11:8] <= PCR_IRQ_MAX
		&& dev_dma0[8:6] <= 3'h4) else $error("routing out of range");
endmodule
bind pcr_config_file pcr_chk chk (.clk_sys, .resetn, .clk_en, .base_sel,
	.io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_hit, .dev_active,
	.dev_base0, .dev_irq_num, .dev_dma0, .soft_reset_pulse);

//--- test/pcr_host_model.sv
`timescale 1ns/1ps
module pcr_host_model
	import pcr_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic [1:0]   base_sel,
	input wire logic [7:0]   io_rdata,
	output logic     [15:0]  io_addr,
	output logic             io_wr,
	output logic             io_rd,
	output logic     [7:0]   io_wdata
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// ==========================================================
	// one byte access, held across the taking edge
	task automatic acc(input logic w, input logic dp, input logic [7:0] d,
		output logic [7:0] r);
		@(negedge clk_sys);
		io_addr = (base_sel[0] ? PCR_BASE_B : PCR_BASE_A) + (dp ? PCR_DATA_OFF : 16'h0000);
		io_wdata = d;
		io_wr = w;
		io_rd = !w;
		@(negedge clk_sys);
		r = io_rdata;
		io_wr = 1'b0;
		io_rd = 1'b0;
		// released bus: no stale value left for the sampler
		io_addr = ~io_addr;
		io_wdata = ~io_wdata;
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic [7:0] r;
		acc(1'b1, 1'b0, ix, r);
		acc(1'b1, 1'b1, d, r);
	endtask
	task automatic rd(input logic [7:0] ix, output logic [7:0] r);
		acc(1'b1, 1'b0, ix, r);
		acc(1'b0, 1'b1, 8'h00, r);
	endtask
endmodule

//--- test/pcr_config_file_tb.sv
`timescale 1ns/1ps
module pcr_config_file_tb;
	import pcr_pkg::*;
	logic                    clk_sys = 1'b0;
	logic                    resetn = 1'b0;
	logic                    clk_en = 1'b1;
	logic                    rail_por_n = 1'b0;
	logic [1:0]              base_sel = PCR_BASE_SEL_A;
	logic [15:0]             io_addr;
	logic                    io_wr, io_rd, hit, pulse;
	logic [7:0]              io_wdata, io_rdata, r;
	logic [PCR_NDEV-1:0]     act, hi, lvl;
	logic [PCR_NDEV*16-1:0]  b0, b1;
	logic [PCR_NDEV*4-1:0]   irq;
	logic [PCR_NDEV*3-1:0]   d0, d1;
	int                      fails = 0;
	int                      tests_run = 0;
	always #4 clk_sys = ~clk_sys;
	pcr_config_file dut (.clk_sys, .resetn, .clk_en, .rail_por_n, .base_sel,
		.io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_hit(hit),
		.dev_active(act), .dev_base0(b0), .dev_base1(b1), .dev_irq_num(irq),
		.dev_irq_high(hi), .dev_irq_level(lvl), .dev_dma0(d0), .dev_dma1(d1),
		.soft_reset_pulse(pulse));
	pcr_host_model host (.clk_sys, .base_sel, .io_rdata, .io_addr, .io_wr,
		.io_rd, .io_wdata);
	// ==========================================================
	// compare helpers and verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ex(input logic [7:0] ix, input logic [7:0] exp);
		host.rd(ix, r);
		chk({8'h00, r}, {8'h00, exp});
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		host.acc(1'b0, 1'b0, 8'h00, r);
		chk({8'h00, r}, 16'h0000);
		ex(PCR_IX_SELECTOR, PCR_ZERO);
		host.wr(PCR_IX_IDENT, 8'hFF);
		ex(PCR_IX_IDENT, PCR_IDENT_VAL);
		ex(PCR_IX_GCFG1, PCR_GCFG1_RST);
		ex(PCR_IX_REV, PCR_REV_VAL);
		host.acc(1'b1, 1'b0, 8'h63, r);
		host.acc(1'b0, 1'b0, 8'h00, r);
		chk({8'h00, r}, 16'h0063);
	endtask
	task automatic t_bank();
		host.wr(PCR_IX_SELECTOR, 8'h02);
		ex(PCR_IX_SELECTOR, 8'h02);
		ex(PCR_IX_DMA0, PCR_DMA_NONE);
		host.wr(PCR_IX_B0_HI, 8'h12);
		host.wr(PCR_IX_B0_LO, 8'h34);
		host.wr(PCR_IX_IRQ_NUM, 8'hFF);
		ex(PCR_IX_IRQ_NUM, 8'h0F);
		host.wr(PCR_IX_IRQ_NUM, 8'h0C);
		host.wr(PCR_IX_IRQ_TYPE, 8'h03);
		host.wr(PCR_IX_DMA0, 8'h03);
		host.wr(PCR_IX_DMA1, 8'hFC);
		ex(PCR_IX_DMA1, 8'h04);
		chk(b0[47:32], 16'h0000);
		host.wr(PCR_IX_ACTIVATE, 8'h01);
		chk(b0[47:32], 16'h1234);
		chk({act[2], hi[2], lvl[2], irq[11:8], d0[8:6], d1[8:6]}, 16'h1F1C);
		host.wr(PCR_IX_GCFG1, 8'h00);
		chk({15'h0, act[2]}, 16'h0000);
		host.wr(PCR_IX_GCFG1, PCR_GCFG1_RST);
		chk({15'h0, act[2]}, 16'h0001);
	endtask
	task automatic t_unmapped();
		host.wr(PCR_IX_B1_HI, 8'h55);
		ex(PCR_IX_B1_HI, PCR_ZERO);
		host.wr(PCR_IX_SELECTOR, PCR_DEV_CLOCK);
		host.wr(PCR_IX_B1_HI, 8'h56);
		ex(PCR_IX_B1_HI, 8'h56);
		host.wr(PCR_IX_ACTIVATE, 8'h01);
		chk(b1[15:0], 16'h5600);
		chk({15'h0, act[0]}, 16'h0001);
		ex(PCR_IX_DMA1, PCR_DMA_NONE);
		host.wr(PCR_IX_SELECTOR, PCR_DEV_HOLE);
		host.wr(PCR_IX_B0_HI, 8'h77);
		ex(PCR_IX_B0_HI, PCR_ZERO);
		ex(PCR_IX_DMA0, PCR_DMA_NONE);
		host.wr(PCR_IX_SELECTOR, 8'h02);
		ex(PCR_IX_B0_HI, 8'h12);
	endtask
	task automatic t_lock();
		host.rd(PCR_IX_GCFG1, r);
		host.wr(PCR_IX_GCFG1, r | 8'hE0);
		host.wr(PCR_IX_GCFG1, 8'h01);
		ex(PCR_IX_GCFG1, 8'hE1);
		host.wr(PCR_IX_GCFG1, 8'h23);
		ex(PCR_IX_GCFG1, 8'hE1);
		ex(PCR_IX_SELECTOR, PCR_ZERO);
		chk({15'h0, act[2]}, 16'h0000);
	endtask
	task automatic t_rail();
		host.wr(PCR_IX_GCFG2, 8'hFF);
		ex(PCR_IX_GCFG2, 8'h72);
		resetn = 1'b0;
		@(negedge clk_sys);
		resetn = 1'b1;
		ex(PCR_IX_GCFG2, 8'h72);
		ex(PCR_IX_GCFG1, PCR_GCFG1_RST);
		rail_por_n = 1'b0;
		@(negedge clk_sys);
		rail_por_n = 1'b1;
		ex(PCR_IX_GCFG2, PCR_GCFG2_RST);
	endtask
	task automatic t_port();
		base_sel = PCR_BASE_SEL_B;
		host.wr(PCR_IX_SELECTOR, 8'h03);
		clk_en = 1'b0;
		host.wr(PCR_IX_SELECTOR, 8'h05);
		clk_en = 1'b1;
		base_sel = PCR_BASE_NOCFG;
		host.wr(PCR_IX_SELECTOR, 8'h06);
		base_sel = PCR_BASE_SEL_B;
		ex(PCR_IX_SELECTOR, 8'h03);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		rail_por_n = 1'b1;
		t_reset();
		t_bank();
		t_unmapped();
		t_lock();
		t_rail();
		t_port();
		test_done();
	end
	// hang guard: far above the longest sequence
	initial begin
		#200000;
		fails++;
		test_done();
	end
endmodule
